// ---- src/pll_ctrl_pkg.sv ----
package pll_ctrl_pkg;
    // register byte addresses (all multiples of four: index * 4)
    localparam logic [11:0] LOCK_CAL_IDX    = 12'h018;
    localparam logic [11:0] LOCK_PIN_IDX    = 12'h01A;
    localparam logic [11:0] REF_SEL_IDX     = 12'h01C;
    localparam logic [11:0] HOLD_CTRL_IDX   = 12'h01D;
    localparam logic [11:0] MON_READ_IDX    = 12'h01F;
    localparam logic [11:0] UPDATE_IDX      = 12'h232;
    localparam logic [13:0] LOCK_CAL_ADDR   = {LOCK_CAL_IDX, 2'b00};
    localparam logic [13:0] LOCK_PIN_ADDR   = {LOCK_PIN_IDX, 2'b00};
    localparam logic [13:0] REF_SEL_ADDR    = {REF_SEL_IDX, 2'b00};
    localparam logic [13:0] HOLD_CTRL_ADDR  = {HOLD_CTRL_IDX, 2'b00};
    localparam logic [13:0] MON_READ_ADDR   = {MON_READ_IDX, 2'b00};
    localparam logic [13:0] UPDATE_ADDR     = {UPDATE_IDX, 2'b00};
    // field positions
    localparam int CAL_START_BIT   = 0;
    localparam int CAL_DIV_LSB     = 1;
    localparam int DLD_DIS_BIT     = 3;
    localparam int LD_CNT_LSB      = 5;
    localparam int REF_PREF_BIT    = 3;
    localparam int AUTO_SW_BIT     = 4;
    localparam int REF_BUF_LSB     = 1;
    localparam int HOLD_EN0_BIT    = 0;
    localparam int EXT_HOLD_BIT    = 1;
    localparam int HOLD_EN2_BIT    = 2;
    localparam int LD_CMP_EN_BIT   = 3;
    localparam int REF_THR_BIT     = 0;
    localparam int CAL_DONE_BIT    = 6;
    localparam int UPDATE_BIT      = 0;
    // reset value and field codes
    localparam logic [7:0] REG_RESET      = 8'h00;
    localparam logic [5:0] LD_CUR_SRC     = 6'h04;
    localparam logic [1:0] REF_BOTH_ON    = 2'h3;
    // lock counts per counter code, calibration length
    localparam logic [7:0] LD_CNT_CODE0   = 8'h05;
    localparam logic [7:0] LD_CNT_CODE1   = 8'h10;
    localparam logic [7:0] LD_CNT_CODE2   = 8'h40;
    localparam logic [7:0] LD_CNT_CODE3   = 8'hFF;
    localparam logic [12:0] CAL_CYCLES    = 13'h1130;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_RUN  = 2'b01,
        CAL_DONE = 2'b10
    } cal_state_t;

    typedef struct packed {
        logic       ref_edge;     // reference-path phase detector event
        logic       fb_edge;      // feedback-path phase detector event
        logic       in_window;    // edges inside lock window this cycle
    } pd_event_t;
endpackage

// ---- src/pll_holdover_vco_calibration.sv ----
`timescale 1ns/10ps
// Contract
// RULE1 - lock loss tristates charge pump in auto holdover
// RULE2 - lock judged from pin; comparator off reads high
// RULE3 - tristate held while no reference edge
// RULE4 - reference edge exit resets B counter only
// RULE5 - no re-entry until lock regained again
// RULE6 - holdover follows selected reference
// RULE7 - counter field sets lock cycles, 00 five
// RULE8 - software keeps digital lock detect enabled
// RULE9 - code 000100b selects current-source lock mode
// RULE10 - external bit zero selects automatic holdover
// RULE11 - holdover needs both enable bits set
// RULE12 - reference control bits and buffer field
// RULE13 - frequency monitor flags, selectable reference threshold
// RULE14 - calibrate bit committed by update starts calibration
// RULE15 - later calibrations need clear, update, set, update
// RULE16 - status bit reads one after calibration
// RULE17 - sync held during calibration, released after
// RULE18 - calibration clock is detector rate over divider
// RULE19 - calibration lasts 4400 calibration clocks
// RULE20 - never self-start on register change
// RULE21 - software recalibrates after divider changes
// RULE22 - software prefers current-source lock pin mode
// RULE23 - done bit zero while calibration runs
module pll_holdover_vco_calibration
    import pll_ctrl_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        resetn_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [13:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    input  wire logic [3:0]  pstrb_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire pd_event_t   pd_event_in,
    input  wire logic        lock_indicator_pin_in,
    input  wire logic        ext_holdover_req_in,
    input  wire logic        first_reference_low_in,
    input  wire logic        second_reference_low_in,
    input  wire logic        vco_low_in,
    output logic             digital_lock_flag_out,
    output logic             charge_pump_hiz_out,
    output logic             b_counter_reset_out,
    output logic             output_sync_out,
    output logic             ld_current_source_out,
    output logic             ref_auto_switch_out,
    output logic             ref_second_sel_out,
    output logic [1:0]       ref_buf_en_out,
    output logic             ref_thr_extended_out
);
    // config registers, shadow copies take effect on update
    logic [7:0]  lock_cal_q, lock_cal_d, lock_pin_q, lock_pin_d;
    logic [7:0]  ref_sel_q, ref_sel_d, hold_q, hold_d, mon_q, mon_d;
    logic [7:0]  act_cal_q, act_cal_d, act_pin_q, act_pin_d;
    logic [7:0]  act_ref_q, act_ref_d, act_hold_q, act_hold_d, act_mon_q, act_mon_d;
    logic        ld_s1_q, ld_s2_q, ext_s1_q, ext_s2_q;
    logic [2:0]  mon_s1_q, mon_s2_q;
    logic [7:0]  lock_cnt_q, lock_cnt_d;
    logic        dld_q, dld_d;
    logic        hold_q_st, hold_d_st, rearm_q, rearm_d, bres_q, bres_d;
    logic        ext_prev_q;
    cal_state_t  cal_st_q, cal_st_d;
    logic [12:0] cal_cnt_q, cal_cnt_d;
    logic [3:0]  div_cnt_q, div_cnt_d;
    logic        cal_done_q, cal_done_d, cal_prev_q, cal_prev_d;
    logic [31:0] prdata_d;

    logic wr_acc, rd_acc, hit, upd, ld_level, hold_en, auto_mode;
    logic lock_lost, cal_tick, cal_rise;
    logic [7:0] lock_need;
    logic [3:0] div_len;

    function automatic logic addr_hit(input logic [13:0] a);
        addr_hit = (a == LOCK_CAL_ADDR) || (a == LOCK_PIN_ADDR) ||
                   (a == REF_SEL_ADDR) || (a == HOLD_CTRL_ADDR) ||
                   (a == MON_READ_ADDR) || (a == UPDATE_ADDR);
    endfunction

    // apb: zero wait states, unmapped addresses flag slverr
    assign pready_out  = 1'b1;
    assign hit         = addr_hit(paddr_in);
    assign pslverr_out = psel_in & penable_in & ~hit;
    assign wr_acc      = psel_in & penable_in & pwrite_in & hit & pstrb_in[0];
    assign rd_acc      = psel_in & penable_in & ~pwrite_in & hit;
    assign upd         = wr_acc & (paddr_in == UPDATE_ADDR) & pwdata_in[UPDATE_BIT];

    // register writes and update commit; nothing here starts calibration
    always_comb begin
        lock_cal_d = lock_cal_q;
        lock_pin_d = lock_pin_q;
        ref_sel_d  = ref_sel_q;
        hold_d     = hold_q;
        mon_d      = mon_q;
        if (wr_acc) begin
            unique case (paddr_in)
                LOCK_CAL_ADDR:  lock_cal_d = pwdata_in[7:0];
                LOCK_PIN_ADDR:  lock_pin_d = {2'b00, pwdata_in[5:0]};
                REF_SEL_ADDR:   ref_sel_d  = pwdata_in[7:0];
                HOLD_CTRL_ADDR: hold_d     = pwdata_in[7:0];
                MON_READ_ADDR:  mon_d      = {7'h00, pwdata_in[REF_THR_BIT]};
                default:        ;
            endcase
        end
        act_cal_d  = upd ? lock_cal_d : act_cal_q; // [RULE14] [RULE20]
        act_pin_d  = upd ? lock_pin_d : act_pin_q;
        act_ref_d  = upd ? ref_sel_d  : act_ref_q;
        act_hold_d = upd ? hold_d     : act_hold_q;
        act_mon_d  = upd ? mon_d      : act_mon_q;
    end

    // read mux, registered data
    always_comb begin
        prdata_d = 32'h0000_0000;
        if (psel_in & ~penable_in & ~pwrite_in) begin
            unique case (paddr_in)
                LOCK_CAL_ADDR:  prdata_d[7:0] = lock_cal_q;
                LOCK_PIN_ADDR:  prdata_d[7:0] = lock_pin_q;
                REF_SEL_ADDR:   prdata_d[7:0] = ref_sel_q;
                HOLD_CTRL_ADDR: prdata_d[7:0] = hold_q;
                MON_READ_ADDR:  prdata_d[7:0] = {1'b0, cal_done_q, 1'b0, mon_s2_q,
                                                 1'b0, mon_q[REF_THR_BIT]}; // [RULE16] [RULE13]
                default:        prdata_d = 32'h0000_0000;
            endcase
        end
    end

    // configuration outputs
    assign ld_current_source_out = (act_pin_q[5:0] == LD_CUR_SRC); // [RULE9]
    assign ref_auto_switch_out   = act_ref_q[AUTO_SW_BIT]; // [RULE12]
    assign ref_second_sel_out    = act_ref_q[REF_PREF_BIT]; // [RULE12]
    assign ref_buf_en_out        = act_ref_q[REF_BUF_LSB+:2]; // [RULE12]
    assign ref_thr_extended_out  = act_mon_q[REF_THR_BIT]; // [RULE13]

    // digital lock detect; counter code picks consecutive count
    always_comb begin
        unique case (act_cal_q[LD_CNT_LSB+:2]) // [RULE7]
            2'b00: lock_need = LD_CNT_CODE0;
            2'b01: lock_need = LD_CNT_CODE1;
            2'b10: lock_need = LD_CNT_CODE2;
            2'b11: lock_need = LD_CNT_CODE3;
        endcase
        lock_cnt_d = lock_cnt_q;
        dld_d      = dld_q;
        if (act_cal_q[DLD_DIS_BIT]) begin
            lock_cnt_d = 8'h00;
            dld_d      = 1'b0;
        end else if (pd_event_in.ref_edge) begin
            if (!pd_event_in.in_window) begin
                lock_cnt_d = 8'h00;
                dld_d      = 1'b0;
            end else if (lock_cnt_q >= lock_need - 8'h01) begin
                lock_cnt_d = lock_need;
                dld_d      = 1'b1;
            end else begin
                lock_cnt_d = lock_cnt_q + 8'h01;
            end
        end
    end
    assign digital_lock_flag_out = dld_q;

    // holdover sequencing
    assign hold_en   = act_hold_q[HOLD_EN0_BIT] & act_hold_q[HOLD_EN2_BIT]; // [RULE11]
    assign auto_mode = ~act_hold_q[EXT_HOLD_BIT]; // [RULE10]
    assign ld_level  = act_hold_q[LD_CMP_EN_BIT] ? ld_s2_q : 1'b1; // [RULE2]
    // sensed on synchronised pin of the selected-reference loop
    assign lock_lost = auto_mode ? ~ld_level : (~ext_s2_q & ext_prev_q); // [RULE6]

    always_comb begin
        hold_d_st = hold_q_st;
        rearm_d   = rearm_q;
        bres_d    = 1'b0;
        if (!hold_en) begin
            hold_d_st = 1'b0;
            rearm_d   = 1'b1;
        end else if (hold_q_st) begin
            // stays tristated until a reference edge arrives in auto mode or with the external request high
            if (pd_event_in.ref_edge && (auto_mode || ext_s2_q)) begin // [RULE3] [RULE6]
                hold_d_st = 1'b0;
                bres_d    = 1'b1; // [RULE4]
                rearm_d   = 1'b0;
            end
        end else if (!rearm_q) begin
            if (dld_q && ld_level) begin // [RULE5]
                rearm_d = 1'b1;
            end
        end else if (lock_lost) begin
            hold_d_st = 1'b1; // [RULE1]
        end
    end
    assign charge_pump_hiz_out = hold_q_st; // [RULE1]
    assign b_counter_reset_out = bres_q; // [RULE4]

    // calibration: rising edge of committed bit, phase detector tick divided
    assign cal_rise = act_cal_q[CAL_START_BIT] & ~cal_prev_q; // [RULE14] [RULE15]
    assign div_len  = 4'h1 << act_cal_q[CAL_DIV_LSB+:2];
    assign cal_tick = pd_event_in.ref_edge && (div_cnt_q + 4'h1 >= div_len); // [RULE18]

    always_comb begin
        cal_st_d   = cal_st_q;
        cal_cnt_d  = cal_cnt_q;
        div_cnt_d  = div_cnt_q;
        cal_done_d = cal_done_q;
        cal_prev_d = act_cal_q[CAL_START_BIT];
        unique case (cal_st_q)
            CAL_IDLE, CAL_DONE: begin
                if (cal_rise) begin
                    cal_st_d   = CAL_RUN;
                    cal_cnt_d  = 13'h0000;
                    div_cnt_d  = 4'h0;
                    cal_done_d = 1'b0; // [RULE23]
                end
            end
            CAL_RUN: begin
                if (pd_event_in.ref_edge) begin
                    div_cnt_d = cal_tick ? 4'h0 : div_cnt_q + 4'h1;
                end
                if (cal_tick) begin
                    if (cal_cnt_q == CAL_CYCLES - 13'h0001) begin // [RULE19]
                        cal_st_d   = CAL_DONE;
                        cal_done_d = 1'b1; // [RULE16]
                    end else begin
                        cal_cnt_d = cal_cnt_q + 13'h0001;
                    end
                end
            end
            default: cal_st_d = CAL_IDLE;
        endcase
    end
    assign output_sync_out = (cal_st_q == CAL_RUN); // [RULE17]

    // synchronisers for pin inputs
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ld_s1_q    <= 1'b0;
            ld_s2_q    <= 1'b0;
            ext_s1_q   <= 1'b1;
            ext_s2_q   <= 1'b1;
            ext_prev_q <= 1'b1;
            mon_s1_q   <= 3'h0;
            mon_s2_q   <= 3'h0;
        end else begin
            ld_s1_q    <= lock_indicator_pin_in;
            ld_s2_q    <= ld_s1_q;
            ext_s1_q   <= ext_holdover_req_in;
            ext_s2_q   <= ext_s1_q;
            ext_prev_q <= ext_s2_q;
            mon_s1_q   <= {vco_low_in, second_reference_low_in, first_reference_low_in};
            mon_s2_q   <= mon_s1_q;
        end
    end

    // state registers
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            lock_cal_q <= REG_RESET;
            lock_pin_q <= REG_RESET;
            ref_sel_q  <= REG_RESET;
            hold_q     <= REG_RESET;
            mon_q      <= REG_RESET;
            act_cal_q  <= REG_RESET;
            act_pin_q  <= REG_RESET;
            act_ref_q  <= REG_RESET;
            act_hold_q <= REG_RESET;
            act_mon_q  <= REG_RESET;
            prdata_out <= 32'h0000_0000;
            lock_cnt_q <= 8'h00;
            dld_q      <= 1'b0;
            hold_q_st  <= 1'b0;
            rearm_q    <= 1'b1;
            bres_q     <= 1'b0;
            cal_st_q   <= CAL_IDLE;
            cal_cnt_q  <= 13'h0000;
            div_cnt_q  <= 4'h0;
            cal_done_q <= 1'b0;
            cal_prev_q <= 1'b0;
        end else begin
            lock_cal_q <= lock_cal_d;
            lock_pin_q <= lock_pin_d;
            ref_sel_q  <= ref_sel_d;
            hold_q     <= hold_d;
            mon_q      <= mon_d;
            act_cal_q  <= act_cal_d;
            act_pin_q  <= act_pin_d;
            act_ref_q  <= act_ref_d;
            act_hold_q <= act_hold_d;
            act_mon_q  <= act_mon_d;
            prdata_out <= rd_acc ? prdata_out : prdata_d;
            lock_cnt_q <= lock_cnt_d;
            dld_q      <= dld_d;
            hold_q_st  <= hold_d_st;
            rearm_q    <= rearm_d;
            bres_q     <= bres_d;
            cal_st_q   <= cal_st_d;
            cal_cnt_q  <= cal_cnt_d;
            div_cnt_q  <= div_cnt_d;
            cal_done_q <= cal_done_d;
            cal_prev_q <= cal_prev_d;
        end
    end

    // checks
    property p_hold_enter;
        @(posedge core_clk_in) disable iff (!resetn_in)
        hold_en && auto_mode && rearm_q && !hold_q_st && !ld_level
            |=> charge_pump_hiz_out;
    endproperty
    a_hold_enter: assert property (p_hold_enter) else $error("no holdover on lock loss"); // [RULE1]

    property p_hold_stay;
        @(posedge core_clk_in) disable iff (!resetn_in)
        charge_pump_hiz_out && !pd_event_in.ref_edge && hold_en |=> charge_pump_hiz_out;
    endproperty
    a_hold_stay: assert property (p_hold_stay) else $error("left holdover without ref"); // [RULE3]

    property p_bres;
        @(posedge core_clk_in) disable iff (!resetn_in)
        $fell(charge_pump_hiz_out) && hold_en |-> b_counter_reset_out;
    endproperty
    a_bres: assert property (p_bres) else $error("b counter not reset on exit"); // [RULE4]

    property p_disabled;
        @(posedge core_clk_in) disable iff (!resetn_in)
        !hold_en |=> !charge_pump_hiz_out;
    endproperty
    a_disabled: assert property (p_disabled) else $error("holdover while disabled"); // [RULE11]

    property p_cal_sync;
        @(posedge core_clk_in) disable iff (!resetn_in)
        cal_rise && cal_st_q != CAL_RUN |=> output_sync_out && !cal_done_q;
    endproperty
    a_cal_sync: assert property (p_cal_sync) else $error("calibration start wrong"); // [RULE17]

    property p_done_low;
        @(posedge core_clk_in) disable iff (!resetn_in)
        output_sync_out |-> !cal_done_q;
    endproperty
    a_done_low: assert property (p_done_low) else $error("done set while calibrating"); // [RULE23]

    property p_cal_end;
        @(posedge core_clk_in) disable iff (!resetn_in)
        $fell(output_sync_out) |-> cal_done_q && cal_cnt_q == CAL_CYCLES - 13'h0001;
    endproperty
    a_cal_end: assert property (p_cal_end) else $error("calibration length wrong"); // [RULE19]

    property p_no_self_start;
        @(posedge core_clk_in) disable iff (!resetn_in)
        !output_sync_out && !cal_rise |=> !output_sync_out;
    endproperty
    a_no_self_start: assert property (p_no_self_start) else $error("self-started calibration"); // [RULE20]

    property p_lock5;
        @(posedge core_clk_in) disable iff (!resetn_in)
        $rose(dld_q) && act_cal_q[LD_CNT_LSB+:2] == 2'b00 |-> lock_cnt_q == 8'h05;
    endproperty
    a_lock5: assert property (p_lock5) else $error("lock count wrong"); // [RULE7]

    // after an exit, nothing re-enters until rearmed by lock and pin
    property p_no_reentry;
        @(posedge core_clk_in) disable iff (!resetn_in)
        hold_en && !hold_q_st && !rearm_q |=> !charge_pump_hiz_out;
    endproperty
    a_no_reentry: assert property (p_no_reentry) else $error("holdover re-entered early"); // [RULE5]

    // comparator off: pin always reads high, so auto mode never fires
    property p_cmp_off;
        @(posedge core_clk_in) disable iff (!resetn_in)
        hold_en && auto_mode && !act_hold_q[LD_CMP_EN_BIT] && !hold_q_st
            |=> !charge_pump_hiz_out;
    endproperty
    a_cmp_off: assert property (p_cmp_off) else $error("holdover with comparator off"); // [RULE2]
endmodule

// ---- tb/pll_far_side_model.sv ----
`timescale 1ns/10ps
// far side: detector edges, lock pin capacitor, frequency monitors
module pll_far_side_model
    import pll_ctrl_pkg::*;
#(
    parameter int CHARGE = 20
) (
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    input  wire logic [7:0] period_in,
    input  wire logic       ref_on_in,
    input  wire logic       locked_in,
    input  wire logic       dld_in,
    output pd_event_t       pd_event_out,
    output logic            lock_pin_out,
    output logic            ref_low_out
);
    logic [7:0] div_q;
    logic [7:0] chg_q;

    // reference edges stop outright when the source is gone
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            div_q <= 8'h00;
            chg_q <= 8'h00;
            pd_event_out <= '0;
        end else begin
            div_q <= (div_q + 8'h01 >= period_in) ? 8'h00 : div_q + 8'h01;
            pd_event_out.ref_edge <= ref_on_in && div_q == 8'h00;
            pd_event_out.fb_edge <= div_q == 8'h00;
            pd_event_out.in_window <= locked_in && div_q == 8'h00;
            // capacitor charges while locked, dumps at once on any unlock
            chg_q <= !dld_in ? 8'h00 : (chg_q < 8'(CHARGE)) ? chg_q + 8'h01 : chg_q;
        end
    end

    // pin only high once charged long enough
    assign lock_pin_out = chg_q == 8'(CHARGE);
    assign ref_low_out  = !ref_on_in;
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
module tb_top
    import pll_ctrl_pkg::*;
;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [13:0] paddr = 14'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        perr;
    logic [7:0]  period = 8'h08;
    logic        ref_on = 1'b1;
    logic        locked = 1'b0;
    logic        ext_req = 1'b1;
    pd_event_t   pd_ev;
    logic        pin;
    logic        ref_low;
    logic        digital_lock_flag;
    logic        hiz;
    logic        brst;
    logic        osync;
    logic        ld_cs;
    logic        auto_sw;
    logic        sec_sel;
    logic [1:0]  buf_en;
    logic        thr_ext;
    logic [31:0] rd;
    logic        err_seen;
    int          fail_count = 0;
    int          checks_done = 0;
    logic [7:0]  holds [5] = '{8'h08, 8'h09, 8'h0C, 8'h0F, 8'h05};

    // free-running core clock
    always #5 clk = ~clk;

    pll_holdover_vco_calibration uut (
        .core_clk_in(clk), .resetn_in(rstn), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hF),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr),
        .pd_event_in(pd_ev), .lock_indicator_pin_in(pin), .ext_holdover_req_in(ext_req),
        .first_reference_low_in(ref_low), .second_reference_low_in(1'b0), .vco_low_in(ref_low),
        .digital_lock_flag_out(digital_lock_flag), .charge_pump_hiz_out(hiz),
        .b_counter_reset_out(brst), .output_sync_out(osync),
        .ld_current_source_out(ld_cs), .ref_auto_switch_out(auto_sw),
        .ref_second_sel_out(sec_sel), .ref_buf_en_out(buf_en),
        .ref_thr_extended_out(thr_ext));

    pll_far_side_model far (
        .clk_in(clk), .resetn_in(rstn), .period_in(period), .ref_on_in(ref_on),
        .locked_in(locked), .dld_in(digital_lock_flag), .pd_event_out(pd_ev),
        .lock_pin_out(pin), .ref_low_out(ref_low));

    task print_verdict;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer; no fixed latency assumed
    task apb(input logic w, input logic [13:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err_seen = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (n >= 20) begin
            check("pready", 1'b0, 1'b1);
            print_verdict;
        end
    endtask

    // writes only reach outputs after the update command
    task wr_upd(input logic [13:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        apb(1'b1, UPDATE_ADDR, 32'h1);
    endtask

    task cycles(input int n);
        repeat (n) @(negedge clk);
    endtask

    // bounded wait on a design or far-side level, sampled mid-cycle
    task wait_for(input int which, input logic v, input int bound);
        logic s;
        for (int n = 0; n < bound; n++) begin
            case (which)
                0: s = hiz;
                1: s = digital_lock_flag;
                2: s = brst;
                3: s = osync;
                4: s = pd_ev.ref_edge;
                default: s = pin;
            endcase
            if (s === v)
                return;
            @(negedge clk);
        end
        check("wait", which, 32'hFF);
        print_verdict;
    endtask

    // count cycles in which the pump is tristated
    task count_hiz(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(negedge clk);
            if (hiz !== 1'b0)
                c++;
        end
    endtask

    task t_regs;
        apb(1'b0, 14'h0004, 32'h0);
        check("unmapped data", rd, 32'h0);
        check("unmapped err", err_seen, 1'b1);
        apb(1'b1, REF_SEL_ADDR, 32'h16);
        cycles(2);
        check("early commit", auto_sw, 1'b0);
        apb(1'b1, UPDATE_ADDR, 32'h1);
        cycles(2);
        check("auto switch", auto_sw, 1'b1);
        check("buffers", buf_en, 2'h3);
        check("pref first", sec_sel, 1'b0);
        apb(1'b1, LOCK_PIN_ADDR, 32'h04);
        apb(1'b1, MON_READ_ADDR, 32'h01);
        wr_upd(REF_SEL_ADDR, 32'h1E);
        cycles(2);
        check("pref second", sec_sel, 1'b1);
        check("cur source", ld_cs, 1'b1);
        check("thr ext", thr_ext, 1'b1);
        apb(1'b0, REF_SEL_ADDR, 32'h0);
        check("readback", rd, 32'h1E);
        $display("test regs done");
    endtask

    task t_lock;
        cycles(40);
        check("no lock", digital_lock_flag, 1'b0);
        @(posedge clk);
        locked <= 1'b1;
        // skip pulses launched before the far side saw the new level
        cycles(2);
        for (int k = 1; k <= 5; k++) begin
            wait_for(4, 1'b1, 40);
            cycles(3);
            if (k == 4)
                check("lock early", digital_lock_flag, 1'b0);
        end
        check("lock five", digital_lock_flag, 1'b1);
        wait_for(5, 1'b1, 100);
        $display("test lock done");
    endtask

    task t_hold;
        int c;
        wr_upd(HOLD_CTRL_ADDR, 32'h0D);
        @(posedge clk);
        locked <= 1'b0;
        wait_for(1, 1'b0, 40);
        @(posedge clk);
        ref_on <= 1'b0;
        wait_for(0, 1'b1, 40);
        count_hiz(40, c);
        check("held", c, 40);
        apb(1'b0, MON_READ_ADDR, 32'h0);
        check("monitors", rd, 32'h15);
        @(posedge clk);
        ref_on <= 1'b1;
        wait_for(2, 1'b1, 30);
        check("exit", hiz, 1'b0);
        cycles(1);
        check("b pulse", brst, 1'b0);
        count_hiz(40, c);
        check("no reentry", c, 0);
        @(posedge clk);
        locked <= 1'b1;
        wait_for(5, 1'b1, 200);
        cycles(4);
        @(posedge clk);
        locked <= 1'b0;
        wait_for(0, 1'b1, 60);
        wait_for(0, 1'b0, 30);
        @(posedge clk);
        locked <= 1'b1;
        $display("test holdover done");
    endtask

    task t_nohold;
        int c;
        foreach (holds[i]) begin
            wr_upd(HOLD_CTRL_ADDR, {24'h0, holds[i]});
            wait_for(5, 1'b1, 200);
            @(posedge clk);
            locked <= 1'b0;
            count_hiz(40, c);
            check("no holdover", c, 0);
            @(posedge clk);
            locked <= 1'b1;
        end
        // external mode: synced falling edge enters, exit on ref edge
        wr_upd(HOLD_CTRL_ADDR, 32'h0F);
        @(posedge clk);
        ext_req <= 1'b0;
        wait_for(0, 1'b1, 20);
        @(posedge clk);
        ext_req <= 1'b1;
        wait_for(0, 1'b0, 30);
        wr_upd(HOLD_CTRL_ADDR, 32'h0);
        $display("test disabled done");
    endtask

    // count detector reference edges while outputs are held
    task run_cal(input int code);
        int n;
        int d;
        int m;
        wait_for(3, 1'b1, 20);
        apb(1'b0, MON_READ_ADDR, 32'h0);
        check("done low", rd[6], 1'b0);
        n = 0;
        m = 0;
        while (osync === 1'b1 && m < 40000) begin
            if (pd_ev.ref_edge === 1'b1)
                n++;
            m++;
            @(negedge clk);
        end
        if (m >= 40000) begin
            check("cal timeout", osync, 1'b0);
            print_verdict;
        end
        d = (4400 << code) - n;
        check("cal length", d >= 0 && d <= 4, 1'b1);
        cycles(2);
        check("sync off", osync, 1'b0);
        apb(1'b0, MON_READ_ADDR, 32'h0);
        check("done high", rd[6], 1'b1);
    endtask

    task t_cal;
        @(posedge clk);
        period <= 8'h02;
        apb(1'b1, LOCK_CAL_ADDR, 32'h01); // dld disable bit left at zero
        cycles(20);
        check("no start", osync, 1'b0);
        apb(1'b1, UPDATE_ADDR, 32'h1);
        run_cal(0);
        wr_upd(LOCK_CAL_ADDR, 32'h03);
        cycles(20);
        check("no self start", osync, 1'b0);
        wr_upd(LOCK_CAL_ADDR, 32'h02);
        wr_upd(LOCK_CAL_ADDR, 32'h03);
        run_cal(1);
        $display("test calibration done");
    endtask

    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        t_regs;
        t_lock;
        t_hold;
        t_nohold;
        t_cal;
        print_verdict;
    end
endmodule
